// ==== interval_timer.sv ====
// Reloadable down-counter timing each pattern's hold interval
`default_nettype none

module interval_timer
  import stepper_pkg::*;
#(
  parameter int W = CNT_W
) (
  input wire logic ref_clk, // 100 MHz clock
  input wire logic rst_b, // Async reset, active low
  input wire logic load, // Reload with a new interval
  input wire logic [W-1:0] loadVal, // Interval in cycles, zero acts as one
  output logic expire // Last cycle of the interval
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } timerState_t;

  timerState_t cur_r;
  timerState_t cur_nxt;

  always_comb begin
    cur_nxt = cur_r;
    if (load) begin
      cur_nxt.cnt = (loadVal == '0) ? W'(MIN_INTERVAL) : loadVal;
    end else if (cur_r.cnt > W'(MIN_INTERVAL)) begin
      cur_nxt.cnt = cur_r.cnt - W'(MIN_INTERVAL);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_r <= '{cnt: W'(MIN_INTERVAL)};
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign expire = (cur_r.cnt == W'(MIN_INTERVAL));

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  AST_TIMER_RELOAD: assert property ( // RQ13
    load && (loadVal > W'(MIN_INTERVAL)) |=> !expire && (cur_r.cnt == $past(loadVal)))
    else $error("Timer did not reload to the requested interval");

endmodule

`default_nettype wire

// ==== stepper_driver_model.sv ====
// Behavioural motor driver model: pulled-down inputs and winding decode
`default_nettype none

module stepper_driver_model
  import stepper_pkg::*;
(
  input wire logic [PHASE_W-1:0] phaseOut, // Sequencer pattern
  input wire logic [PHASE_W-1:0] phaseOe, // Sequencer drive enables
  output logic [PHASE_W-1:0] pinLvl, // Resolved driver input level
  output logic [1:0] windOn // Windings energised
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Input pins
  // ----------------------------------------------------------------
  // Released inputs fall to the pull-down level
  always_comb begin
    for (int i = 0; i < PHASE_W; i++) begin
      pinLvl[i] = phaseOe[i] ? phaseOut[i] : 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Windings
  // ----------------------------------------------------------------
  assign windOn[1] = pinLvl[3] & ~pinLvl[2];
  assign windOn[0] = pinLvl[1] & ~pinLvl[0];
endmodule

`default_nettype wire

// ==== stepper_phase_sequencer.sv ====
// Stepper winding phase sequencer: full, half and dead-time stepping
//
// Operation
// [RQ1] Full step cycles 0x09, 0x0A, 0x06, 0x05
// [RQ2] Half step cycles eight patterns, then repeats
// [RQ3] Dead-time single phase precedes each full step
// [RQ4] Dead-time interval programmable, up to step interval
// [RQ5] Each pattern held for programmable energising interval
// [RQ6] After reset all phases driven low
// [RQ7] Pattern presented on four output bits
// [RQ8] Driver energises winding on high/low inputs
// [RQ9] Standby releases outputs, pull-downs keep phases off
// [RQ10] Running wraps continuously over selected table
// [RQ11] Counterclockwise walks table in reverse
// [RQ12] Run, direction, mode sampled at step boundary
// [RQ13] Intervals counted by reloaded down-counter
`default_nettype none

module stepper_phase_sequencer
  import stepper_pkg::*;
#(
  parameter int INTERVAL_W = CNT_W
) (
  input wire logic ref_clk, // 100 MHz clock
  input wire logic rst_b, // Async reset, active low
  input wire logic runEn, // Step while high
  input wire logic dirCcw, // 1 reverse table order, 0 forward
  input wire logic halfStep, // 1 half-step table, 0 full-step
  input wire logic deadEn, // Dead-time before each full step
  input wire logic standby, // Release outputs, stop stepping
  input wire logic [INTERVAL_W-1:0] energiseLen, // Step hold in cycles
  input wire logic [INTERVAL_W-1:0] deadLen, // Dead-time hold in cycles
  output logic [PHASE_W-1:0] phaseOut, // Winding pattern, bit 3 to bit 0
  output logic [PHASE_W-1:0] phaseOe, // Drive enables, high while driven
  output logic running // Sequencer is stepping
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    seqState_t st;
    logic [2:0] idx;
    logic ccwL;
    logic halfL;
    logic deadL;
    logic [PHASE_W-1:0] phase;
    logic [PHASE_W-1:0] oe;
    logic running;
  } seqRegs_t;

  localparam seqRegs_t SEQ_RESET = '{
    st: IDLE,
    idx: IDX_FIRST,
    ccwL: 1'b0,
    halfL: 1'b0,
    deadL: 1'b0,
    phase: PHASE_OFF,
    oe: OE_ALL,
    running: 1'b0
  };

  seqRegs_t cur_r;
  seqRegs_t cur_nxt;
  logic timerLoad;
  logic [INTERVAL_W-1:0] timerVal;
  logic expire;
  logic boundary;
  logic [2:0] nextIdx;

  // ----------------------------------------------------------------
  // Interval timer
  // ----------------------------------------------------------------
  interval_timer #(
    .W(INTERVAL_W)
  ) i_interval_timer (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .load(timerLoad),
    .loadVal(timerVal),
    .expire(expire)
  );

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  always_comb begin
    cur_nxt = cur_r;
    timerLoad = 1'b0;
    timerVal = energiseLen;
    boundary = (cur_r.st == IDLE) || expire;
    nextIdx = (cur_r.st == IDLE) ? IDX_FIRST : stepIndex(cur_r.idx, dirCcw, halfStep); // RQ11
    if (standby) begin
      cur_nxt.st = IDLE; // RQ9
      cur_nxt.phase = PHASE_OFF;
      cur_nxt.oe = OE_NONE; // RQ9
      cur_nxt.running = 1'b0;
    end else if (boundary && cur_r.st == DEAD) begin
      // Dead-time over: energise the full step it precedes
      cur_nxt.st = ENERGISE;
      cur_nxt.phase = fullPattern(cur_r.idx[1:0]); // RQ3
      timerLoad = 1'b1; // RQ13
      timerVal = energiseLen; // RQ5
    end else if (boundary) begin
      cur_nxt.ccwL = dirCcw; // RQ12
      cur_nxt.halfL = halfStep; // RQ12
      cur_nxt.deadL = deadEn; // RQ12
      cur_nxt.oe = OE_ALL; // RQ7
      if (!runEn) begin
        cur_nxt.st = IDLE;
        cur_nxt.phase = PHASE_OFF; // RQ6
        cur_nxt.running = 1'b0;
      end else begin
        cur_nxt.idx = nextIdx; // RQ10
        cur_nxt.running = 1'b1;
        timerLoad = 1'b1; // RQ13
        if (!halfStep && deadEn) begin
          cur_nxt.st = DEAD;
          cur_nxt.phase = deadPattern(nextIdx[1:0]); // RQ3
          timerVal = deadLen; // RQ4
        end else begin
          cur_nxt.st = ENERGISE;
          cur_nxt.phase = halfStep ? halfPattern(nextIdx) : fullPattern(nextIdx[1:0]); // RQ1 RQ2
          timerVal = energiseLen; // RQ5
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_r <= SEQ_RESET; // RQ6
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign phaseOut = cur_r.phase; // RQ7
  assign phaseOe = cur_r.oe;
  assign running = cur_r.running;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [INTERVAL_W:0] dwell_r;
  logic [INTERVAL_W-1:0] heldLen_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dwell_r <= '0;
      heldLen_r <= '0;
    end else if (timerLoad && !standby) begin
      dwell_r <= (INTERVAL_W+1)'(1);
      heldLen_r <= (timerVal == '0) ? INTERVAL_W'(MIN_INTERVAL) : timerVal;
    end else begin
      dwell_r <= dwell_r + (INTERVAL_W+1)'(1);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence deadEnds;
    cur_r.st == DEAD && expire && !standby;
  endsequence

  sequence stepFollows;
    cur_r.st == ENERGISE && cur_r.phase == fullPattern(cur_r.idx[1:0]);
  endsequence

  sequence fwdFullAdvance;
    cur_r.st == ENERGISE && expire && !standby && runEn && !halfStep && !deadEn && !dirCcw;
  endsequence

  AST_FULL_TABLE: assert property ( // RQ1
    cur_r.st == ENERGISE && !cur_r.halfL |-> cur_r.phase == fullPattern(cur_r.idx[1:0]))
    else $error("Full-step pattern does not match table entry");

  AST_HALF_TABLE: assert property ( // RQ2
    cur_r.st == ENERGISE && cur_r.halfL |-> cur_r.phase == halfPattern(cur_r.idx))
    else $error("Half-step pattern does not match table entry");

  AST_DEAD_THEN_STEP: assert property ( // RQ3
    deadEnds |=> stepFollows)
    else $error("Dead-time pattern not followed by its full step");

  AST_DEAD_PATTERN: assert property ( // RQ3
    cur_r.st == DEAD |-> !cur_r.halfL && cur_r.phase == deadPattern(cur_r.idx[1:0]))
    else $error("Dead-time pattern wrong or used in half-step mode");

  AST_HOLD_INTERVAL: assert property ( // RQ5
    cur_r.st != IDLE && expire && !standby |-> dwell_r == {1'b0, heldLen_r})
    else $error("Pattern not held for the programmed interval");

  AST_IDLE_LOW: assert property ( // RQ6
    !cur_r.running |-> cur_r.phase == PHASE_OFF)
    else $error("Phase outputs not low while stopped");

  AST_STANDBY_RELEASE: assert property ( // RQ9
    standby |=> phaseOe == OE_NONE && phaseOut == PHASE_OFF && !running)
    else $error("Outputs still driven in standby");

  AST_FULL_WRAP: assert property ( // RQ10
    fwdFullAdvance |=> cur_r.idx == (($past(cur_r.idx) + IDX_STEP) & IDX_MASK_FULL))
    else $error("Forward full step did not advance with wrap");

  AST_REVERSE: assert property ( // RQ11
    cur_r.st == ENERGISE && expire && !standby && runEn && dirCcw && halfStep
    |=> cur_r.idx == ($past(cur_r.idx) - IDX_STEP))
    else $error("Reverse half step did not walk table backwards");

  AST_CTRL_HELD: assert property ( // RQ12
    cur_r.st != IDLE && !expire && !standby
    |=> $stable(cur_r.ccwL) && $stable(cur_r.halfL) && $stable(cur_r.deadL))
    else $error("Controls taken between step boundaries");

endmodule

`default_nettype wire

// ==== stepper_phase_sequencer_test.sv ====
// Self-checking bench for the stepper phase sequencer
`default_nettype none

module stepper_phase_sequencer_test
  import stepper_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int LEN = 3;
  localparam logic [3:0] FULL_SEQ [4] = '{4'h9, 4'hA, 4'h6, 4'h5};
  localparam logic [3:0] HALF_SEQ [8] = '{4'h8, 4'hA, 4'h2, 4'h6, 4'h4, 4'h5, 4'h1, 4'h9};
  localparam logic [3:0] DEAD_SEQ [4] = '{4'h1, 4'h8, 4'h2, 4'h4};
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic runEn = 1'b0;
  logic dirCcw = 1'b0;
  logic halfStep = 1'b0;
  logic deadEn = 1'b0;
  logic standby = 1'b0;
  logic [15:0] energiseLen = 16'h0003;
  logic [15:0] deadLen = 16'h0002;
  logic [3:0] phaseOut;
  logic [3:0] phaseOe;
  logic [3:0] pinLvl;
  logic [1:0] windOn;
  logic running;
  int n_mismatch = 0;
  int n_checks = 0;

  always #5 ref_clk = ~ref_clk;

  stepper_phase_sequencer i_stepper_phase_sequencer (
    .ref_clk(ref_clk), .rst_b(rst_b), .runEn(runEn), .dirCcw(dirCcw),
    .halfStep(halfStep), .deadEn(deadEn), .standby(standby),
    .energiseLen(energiseLen), .deadLen(deadLen), .phaseOut(phaseOut),
    .phaseOe(phaseOe), .running(running)
  );

  stepper_driver_model i_stepper_driver_model (
    .phaseOut(phaseOut), .phaseOe(phaseOe), .pinLvl(pinLvl), .windOn(windOn)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Pattern must stand for len cycles
  task automatic chk(input logic [3:0] exp, input int len);
    repeat (len) begin
      @(posedge ref_clk);
      #1;
      cmp(phaseOut, exp);
      cmp(pinLvl, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    cmp(phaseOut, PHASE_OFF);
    cmp(phaseOe, OE_ALL);
    cmp({3'h0, running}, 4'h0);
    rst_b = 1'b1;
    chk(PHASE_OFF, 1);
    runEn = 1'b1;
    for (int i = 0; i < 4; i++) chk(FULL_SEQ[i], LEN);
    cmp({3'h0, running}, 4'h1);
    chk(4'h9, 1);
    cmp({2'h0, windOn}, 4'h2);
    dirCcw = 1'b1;
    chk(4'h9, LEN - 1);
    for (int i = 3; i >= 0; i--) chk(FULL_SEQ[i], LEN);
    chk(4'h5, 1);
    runEn = 1'b0;
    chk(4'h5, LEN - 1);
    chk(PHASE_OFF, 1);
    cmp({3'h0, running}, 4'h0);
    cmp(phaseOe, OE_ALL);
    standby = 1'b1;
    chk(PHASE_OFF, 1);
    cmp(phaseOe, OE_NONE);
    cmp({2'h0, windOn}, 4'h0);
    halfStep = 1'b1;
    dirCcw = 1'b0;
    runEn = 1'b1;
    standby = 1'b0;
    for (int i = 0; i < 8; i++) chk(HALF_SEQ[i], LEN);
    chk(4'h8, 1);
    dirCcw = 1'b1;
    chk(4'h8, LEN - 1);
    for (int i = 7; i >= 0; i--) chk(HALF_SEQ[i], LEN);
    standby = 1'b1;
    chk(PHASE_OFF, 1);
    halfStep = 1'b0;
    dirCcw = 1'b0;
    deadEn = 1'b1;
    standby = 1'b0;
    chk(4'h1, 2);
    chk(4'h9, 1);
    deadLen = 16'h0003;
    chk(4'h9, LEN - 1);
    for (int i = 1; i < 4; i++) begin
      chk(DEAD_SEQ[i], LEN);
      chk(FULL_SEQ[i], LEN);
    end
    chk(4'h1, LEN);
    finish_test();
  end

  initial begin
    #4000;
    n_mismatch++;
    finish_test();
  end
endmodule

`default_nettype wire

// ==== stepper_pkg.sv ====
// Shared constants, pattern tables and helpers for the stepper phase sequencer
`default_nettype none

package stepper_pkg;

  // ----------------------------------------------------------------
  // Widths and reference values
  // ----------------------------------------------------------------
  localparam int PHASE_W = 4;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] ENERGISE_REF = 16'h0300;
  localparam logic [CNT_W-1:0] MIN_INTERVAL = 16'h0001;
  localparam logic [PHASE_W-1:0] PHASE_OFF = 4'h0;
  localparam logic [PHASE_W-1:0] OE_ALL = 4'hF;
  localparam logic [PHASE_W-1:0] OE_NONE = 4'h0;
  localparam logic [2:0] IDX_FIRST = 3'h0;
  localparam logic [2:0] IDX_MASK_FULL = 3'h3;
  localparam logic [2:0] IDX_MASK_HALF = 3'h7;
  localparam logic [2:0] IDX_STEP = 3'h1;

  // ----------------------------------------------------------------
  // Pattern tables, bit 3 down to bit 0
  // ----------------------------------------------------------------
  localparam logic [PHASE_W-1:0] FULL_TAB [4] = '{4'h9, 4'hA, 4'h6, 4'h5};
  localparam logic [PHASE_W-1:0] HALF_TAB [8] =
    '{4'h8, 4'hA, 4'h2, 4'h6, 4'h4, 4'h5, 4'h1, 4'h9};
  localparam logic [PHASE_W-1:0] DEAD_TAB [4] = '{4'h1, 4'h8, 4'h2, 4'h4};

  typedef enum logic [1:0] {IDLE, DEAD, ENERGISE} seqState_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [PHASE_W-1:0] fullPattern(input logic [1:0] i);
    return FULL_TAB[i];
  endfunction

  function automatic logic [PHASE_W-1:0] halfPattern(input logic [2:0] i);
    return HALF_TAB[i];
  endfunction

  function automatic logic [PHASE_W-1:0] deadPattern(input logic [1:0] i);
    return DEAD_TAB[i];
  endfunction

  // Next table index, wrapping at the selected sequence length
  function automatic logic [2:0] stepIndex(input logic [2:0] i, input logic ccw,
                                           input logic half);
    logic [2:0] mask;
    logic [2:0] n;
    mask = half ? IDX_MASK_HALF : IDX_MASK_FULL;
    n = ccw ? (i - IDX_STEP) : (i + IDX_STEP);
    return n & mask;
  endfunction

endpackage

`default_nettype wire
